// [ahsi_core.sv]
// module: processor-side bus, holding registers and status of the adapter
`timescale 1ns/10ps
// ------------------------------------------------------------
// Operation
// - read_not_write high takes bus data in
// - enabled event pulls intr_req_n low, sets bit7
// - bits 5,6 modem; 3,4 holding flags, gated
// - select lines plus direction pick the register
// - transfers only while bus_clock high, selected
// - reset puts every register at defined state
// - select 00: write transmit, read receive
// - transmit bit 0 first, extra bits ignored
// - receive bit 0 first, high bits zero
// - parity never stored in receive register
// - status bits 6..3 are interrupt conditions
// - bit 7 marks an interrupt condition occurred
// - bits 2..0 overrun, framing, parity
// - error bits never raise an interrupt
// - receive full sets on load, clears on read
// - transmit empty sets on move, clears on write
// - error bits clear after receive data read
// - bit 7 clears when status is read
// ------------------------------------------------------------
module ahsi_core (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic hw_reset_n,
    // processor bus
    input wire logic bus_clock,
    input wire logic chip_sel_hi,
    input wire logic chip_sel_lo_n,
    input wire logic reg_sel_hi,
    input wire logic reg_sel_lo,
    input wire logic read_not_write,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic intr_req_n,
    // configuration from command and control
    input wire logic [1:0] word_len,
    input wire ahsi_pkg::ahsi_irq_en_t irq_en,
    // modem lines
    input wire logic set_ready_n,
    input wire logic carrier_detect_n,
    // transmit stream toward shift register
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    // receive stream from shift register
    input wire ahsi_pkg::ahsi_rx_word_t rx_word,
    input wire logic rx_valid,
    output logic rx_ready
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // word length mask, shared by both directions
    function automatic logic [7:0] wl_mask(input logic [1:0] wl);
        case (wl)
            ahsi_pkg::WL_8: wl_mask = ahsi_pkg::MASK_8;
            ahsi_pkg::WL_7: wl_mask = ahsi_pkg::MASK_7;
            ahsi_pkg::WL_6: wl_mask = ahsi_pkg::MASK_6;
            default: wl_mask = ahsi_pkg::MASK_5;
        endcase
    endfunction

    logic rst_i;
    logic acc, acc_prev_r, acc_start;
    logic [1:0] sel;
    logic wr_data, rd_data, rd_stat, wr_stat;
    logic [7:0] tx_hold_r, tx_hold_nxt, rx_hold_r, rx_hold_nxt;
    logic tx_empty_r, tx_empty_nxt, rx_full_r, rx_full_nxt;
    logic ovr_r, ovr_nxt, fe_r, fe_nxt, pe_r, pe_nxt;
    logic irq_r, irq_nxt, irq_pin_r;
    logic [1:0] modem_r, modem_nxt, modem_now;
    logic modem_frz_r, modem_frz_nxt;
    logic [7:0] buf_r [ahsi_pkg::BUF_DEPTH];
    logic [7:0] buf_nxt [ahsi_pkg::BUF_DEPTH];
    logic [ahsi_pkg::BUF_DEPTH-1:0] vld_r, vld_nxt;
    logic push, pop, rx_take, ev_rx, ev_tx, ev_modem, ev_any;
    logic [7:0] status, dout_r, dout_nxt;
    logic oe_r, oe_nxt, rx_rdy_r;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // pin reset and core reset act alike
    assign rst_i = rst | ~hw_reset_n;
    // one action per high phase, so reads clear flags only once
    assign acc = chip_sel_hi & ~chip_sel_lo_n & bus_clock;
    assign acc_start = acc & ~acc_prev_r;
    assign sel = {reg_sel_hi, reg_sel_lo};
    // high direction carries bus data inward
    assign wr_data = acc_start & read_not_write
        & (sel == ahsi_pkg::SEL_DATA);
    assign rd_data = acc_start & ~read_not_write
        & (sel == ahsi_pkg::SEL_DATA);
    assign rd_stat = acc_start & ~read_not_write
        & (sel == ahsi_pkg::SEL_STATUS);
    // write to status is the program reset
    assign wr_stat = acc_start & read_not_write
        & (sel == ahsi_pkg::SEL_STATUS);

    // ------------------------------------------------------------
    // events and status image
    // ------------------------------------------------------------
    assign modem_now = {set_ready_n, carrier_detect_n};
    assign push = ~tx_empty_r & ~vld_r[1] & ~wr_data;
    assign pop = vld_r[0] & tx_ready;
    assign rx_take = rx_valid & rx_rdy_r;
    // only the four conditions feed the interrupt, never errors
    assign ev_rx = rx_take & ~rx_full_r & irq_en.rx_en;
    assign ev_tx = push & irq_en.tx_en;
    assign ev_modem = ~modem_frz_r & (modem_now != modem_r)
        & irq_en.modem_en;
    assign ev_any = ev_rx | ev_tx | ev_modem;
    assign status = {irq_r, modem_r, tx_empty_r, rx_full_r,
        ovr_r, fe_r, pe_r};

    // ------------------------------------------------------------
    // next-state logic for registers and flags
    // ------------------------------------------------------------
    always_comb begin
        tx_hold_nxt = tx_hold_r;
        tx_empty_nxt = tx_empty_r;
        rx_hold_nxt = rx_hold_r;
        rx_full_nxt = rx_full_r;
        ovr_nxt = ovr_r;
        fe_nxt = fe_r;
        pe_nxt = pe_r;
        irq_nxt = irq_r;
        modem_nxt = modem_r;
        modem_frz_nxt = modem_frz_r;
        dout_nxt = dout_r;
        oe_nxt = oe_r & acc;
        if (wr_data) begin
            // bits past the word length are dropped here
            tx_hold_nxt = data_in & wl_mask(word_len);
            tx_empty_nxt = 1'b0;
        end else if (push) begin
            tx_empty_nxt = 1'b1;
        end
        // reads clear first, so a same-cycle arrival wins
        if (rd_data) begin
            rx_full_nxt = 1'b0;
            ovr_nxt = 1'b0;
            fe_nxt = 1'b0;
            pe_nxt = 1'b0;
        end
        if (wr_stat) begin
            ovr_nxt = 1'b0;
        end
        if (rx_take && rx_full_r && !rd_data) begin
            ovr_nxt = 1'b1;
        end else if (rx_take) begin
            // parity already stripped, high bits forced to zero
            rx_hold_nxt = rx_word.data & wl_mask(word_len);
            rx_full_nxt = 1'b1;
            fe_nxt = rx_word.framing_err;
            pe_nxt = rx_word.parity_err;
        end
        // with modem_en set, modem bits freeze after a change until status is read
        if (rd_stat) begin
            irq_nxt = 1'b0;
            modem_frz_nxt = 1'b0;
        end
        if (!modem_frz_r && modem_now != modem_r) begin
            modem_nxt = modem_now;
            modem_frz_nxt = irq_en.modem_en;
        end
        if (ev_any) begin
            irq_nxt = 1'b1;
        end
        if (acc_start && !read_not_write) begin
            oe_nxt = 1'b1;
            case (sel)
                ahsi_pkg::SEL_DATA: dout_nxt = rx_hold_r;
                ahsi_pkg::SEL_STATUS: dout_nxt = status;
                default: dout_nxt = ahsi_pkg::DATA_RST;
            endcase
        end
    end

    // register stage for flags and holding registers
    always_ff @(posedge clk) begin
        if (rst_i) begin
            tx_hold_r <= ahsi_pkg::DATA_RST;
            rx_hold_r <= ahsi_pkg::DATA_RST;
            tx_empty_r <= ahsi_pkg::TX_EMPTY_RST;
            rx_full_r <= 1'b0;
            ovr_r <= 1'b0;
            fe_r <= 1'b0;
            pe_r <= 1'b0;
            irq_r <= 1'b0;
            modem_r <= ahsi_pkg::MODEM_RST;
            modem_frz_r <= 1'b0;
            dout_r <= ahsi_pkg::DATA_RST;
            oe_r <= 1'b0;
            acc_prev_r <= 1'b0;
            irq_pin_r <= 1'b1;
            rx_rdy_r <= 1'b0;
        end else begin
            tx_hold_r <= tx_hold_nxt;
            rx_hold_r <= rx_hold_nxt;
            tx_empty_r <= tx_empty_nxt;
            rx_full_r <= rx_full_nxt;
            ovr_r <= ovr_nxt;
            fe_r <= fe_nxt;
            pe_r <= pe_nxt;
            irq_r <= irq_nxt;
            modem_r <= modem_nxt;
            modem_frz_r <= modem_frz_nxt;
            dout_r <= dout_nxt;
            oe_r <= oe_nxt;
            acc_prev_r <= acc;
            irq_pin_r <= ~irq_nxt;
            rx_rdy_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // two-entry transmit buffer, head always in slot 0
    // ------------------------------------------------------------
    // a stalled shift register backs up into the holding register
    always_comb begin
        buf_nxt = buf_r;
        vld_nxt = vld_r;
        if (pop) begin
            buf_nxt[0] = buf_r[1];
            vld_nxt = {1'b0, vld_r[1]};
        end
        if (push) begin
            if (vld_nxt[0]) begin
                buf_nxt[1] = tx_hold_r;
                vld_nxt[1] = 1'b1;
            end else begin
                buf_nxt[0] = tx_hold_r;
                vld_nxt[0] = 1'b1;
            end
        end
    end

    // buffer storage
    always_ff @(posedge clk) begin
        if (rst_i) begin
            for (int i = 0; i < ahsi_pkg::BUF_DEPTH; i++) begin
                buf_r[i] <= ahsi_pkg::DATA_RST;
            end
            vld_r <= '0;
        end else begin
            buf_r <= buf_nxt;
            vld_r <= vld_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign data_out = dout_r;
    assign data_oe = oe_r;
    assign intr_req_n = irq_pin_r;
    assign tx_data = buf_r[0]; // shifter sends bit 0 first
    assign tx_valid = vld_r[0];
    assign rx_ready = rx_rdy_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_read_drives_bus: assert property (@(posedge clk) disable iff (rst_i)
        (acc_start && !read_not_write) |=> data_oe)
        else $error("read did not drive the bus");
    a_oe_needs_access: assert property (@(posedge clk) disable iff (rst_i)
        data_oe |-> $past(acc))
        else $error("bus driven outside an access");
    a_irq_pin_low: assert property (@(posedge clk) disable iff (rst_i)
        $rose(irq_r) |-> !intr_req_n)
        else $error("interrupt pin not low with bit 7");
    a_irq_has_cause: assert property (@(posedge clk) disable iff (rst_i)
        $rose(irq_r) |-> $past(ev_any))
        else $error("interrupt without enabled condition");
    a_stat_read_clr: assert property (@(posedge clk) disable iff (rst_i)
        (rd_stat && !ev_any) |=> (!irq_r && intr_req_n))
        else $error("status read did not clear bit 7");
    a_rx_full_set: assert property (@(posedge clk) disable iff (rst_i)
        (rx_take && !rx_full_r) |=> rx_full_r)
        else $error("receive full not set on load");
    a_tx_empty_clr: assert property (@(posedge clk) disable iff (rst_i)
        wr_data |=> !tx_empty_r)
        else $error("transmit empty not cleared by write");
    a_err_read_clr: assert property (@(posedge clk) disable iff (rst_i)
        (rd_data && !rx_take) |=> !(ovr_r || fe_r || pe_r))
        else $error("error bits survived data read");
    a_reset_values: assert property (@(posedge clk)
        rst_i |=> (tx_empty_r && !irq_r && !rx_full_r && !ovr_r && intr_req_n))
        else $error("wrong status after reset");
    // judged at the load, since word length may change while the word waits
    a_rx_high_zero: assert property (@(posedge clk) disable iff (rst_i)
        (rx_take && (!rx_full_r || rd_data))
        |=> ((rx_hold_r & ~wl_mask($past(word_len))) == 8'h00))
        else $error("receive bits past word length set");
    c_rx_then_read: cover property (@(posedge clk) disable iff (rst_i)
        rx_take ##[1:20] rd_data);
    c_tx_stall_full: cover property (@(posedge clk) disable iff (rst_i)
        (vld_r == 2'h3) && !tx_empty_r);
    c_overrun: cover property (@(posedge clk) disable iff (rst_i)
        $rose(ovr_r));
endmodule

// [ahsi_cpu_model.sv]
// processor bus model that runs register cycles against the adapter
`timescale 1ns/10ps
module ahsi_cpu_model (
    // clock
    input wire logic clk,
    // bus pins toward the adapter
    output logic bus_clock,
    output logic chip_sel_hi,
    output logic chip_sel_lo_n,
    output logic reg_sel_hi,
    output logic reg_sel_lo,
    output logic read_not_write,
    output logic [7:0] data_in,
    // answer from the adapter
    input wire logic [7:0] data_out,
    input wire logic data_oe
);
    // idle bus: deselected, phase clock low
    initial begin
        bus_clock = 1'b0;
        chip_sel_hi = 1'b0;
        chip_sel_lo_n = 1'b1;
        {reg_sel_hi, reg_sel_lo} = 2'h0;
        read_not_write = 1'b0;
        data_in = 8'h00;
    end
    // one access, then a low phase so the next one is a fresh rise
    task automatic access(input logic [1:0] sel, input logic rnw, input logic [7:0] wd,
                          output logic [7:0] rd, output logic oe);
        @(posedge clk);
        #1;
        {reg_sel_hi, reg_sel_lo} = sel;
        read_not_write = rnw;
        data_in = wd;
        chip_sel_hi = 1'b1;
        chip_sel_lo_n = 1'b0;
        bus_clock = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rd = data_out;
        oe = data_oe;
        bus_clock = 1'b0;
        chip_sel_hi = 1'b0;
        chip_sel_lo_n = 1'b1;
        data_in = ~wd; // released lines must not keep the old value
        @(posedge clk);
        #1;
    endtask
endmodule

// [ahsi_host_status_interface_test.sv]
// self-checking bench for the adapter's processor side
`timescale 1ns/10ps
module ahsi_host_status_interface_test;
    logic clk, rst, hw_reset_n, bus_clock, chip_sel_hi, chip_sel_lo_n, reg_sel_hi, reg_sel_lo;
    logic read_not_write, data_oe, intr_req_n, set_ready_n, carrier_detect_n;
    logic tx_valid, tx_ready, rx_valid, rx_ready;
    logic [7:0] data_in, data_out, tx_data;
    logic [1:0] word_len;
    ahsi_pkg::ahsi_irq_en_t irq_en;
    ahsi_pkg::ahsi_rx_word_t rx_word;
    int mismatches = 0;
    int n_checks = 0;

    ahsi_core u_ahsi_core (.clk(clk), .rst(rst), .hw_reset_n(hw_reset_n),
        .bus_clock(bus_clock), .chip_sel_hi(chip_sel_hi), .chip_sel_lo_n(chip_sel_lo_n),
        .reg_sel_hi(reg_sel_hi), .reg_sel_lo(reg_sel_lo), .read_not_write(read_not_write),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .intr_req_n(intr_req_n),
        .word_len(word_len), .irq_en(irq_en), .set_ready_n(set_ready_n),
        .carrier_detect_n(carrier_detect_n), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready));
    ahsi_cpu_model u_ahsi_cpu_model (.clk(clk), .bus_clock(bus_clock),
        .chip_sel_hi(chip_sel_hi), .chip_sel_lo_n(chip_sel_lo_n), .reg_sel_hi(reg_sel_hi),
        .reg_sel_lo(reg_sel_lo), .read_not_write(read_not_write), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe));

    // free-running system clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(logic [1:0] sel, logic [7:0] exp, string what);
        logic [7:0] d;
        logic oe;
        u_ahsi_cpu_model.access(sel, 1'b0, 8'h00, d, oe);
        chk(what, exp, d);
        chk("read drive", 8'h01, {7'h00, oe});
    endtask
    task automatic wr(logic [1:0] sel, logic [7:0] wd);
        logic [7:0] d;
        logic oe;
        u_ahsi_cpu_model.access(sel, 1'b1, wd, d, oe);
        chk("write drive", 8'h00, {7'h00, oe});
    endtask
    task automatic rx_put(logic [7:0] d, logic fe, logic pe);
        rx_word = '{data: d, framing_err: fe, parity_err: pe};
        rx_valid = 1'b1;
        @(posedge clk);
        #1;
        rx_valid = 1'b0;
        rx_word = '{data: ~d, framing_err: ~fe, parity_err: ~pe};
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rd(ahsi_pkg::SEL_STATUS, 8'h70, "status after reset");
        chk("irq line idle", 8'h01, {7'h00, intr_req_n});
        chk("rx ready", 8'h01, {7'h00, rx_ready});
        rd(ahsi_pkg::SEL_DATA, 8'h00, "receive after reset");
        rd(ahsi_pkg::SEL_COMMAND, 8'h00, "command read");
        rd(ahsi_pkg::SEL_CONTROL, 8'h00, "control read");
        $display("done t_reset");
    endtask
    // fills the two-entry buffer until the holding register backs up
    task automatic t_tx;
        logic [7:0] q[$];
        irq_en = '{rx_en: 1'b0, tx_en: 1'b1, modem_en: 1'b0};
        wr(ahsi_pkg::SEL_DATA, 8'h15);
        repeat (2) @(posedge clk);
        #1;
        chk("irq line set", 8'h00, {7'h00, intr_req_n});
        rd(ahsi_pkg::SEL_STATUS, 8'hf0, "status tx moved");
        chk("irq line cleared", 8'h01, {7'h00, intr_req_n});
        word_len = 2'h3;
        wr(ahsi_pkg::SEL_DATA, 8'hff);
        wr(ahsi_pkg::SEL_DATA, 8'h3c);
        rd(ahsi_pkg::SEL_STATUS, 8'he0, "status tx full");
        irq_en = '0;
        tx_ready = 1'b1;
        // look off the edge: what stands now is taken at the next edge
        for (int i = 0; i < 20 && q.size() < 3; i++) begin
            if (tx_valid === 1'b1) q.push_back(tx_data);
            @(posedge clk);
            #1;
        end
        tx_ready = 1'b0;
        while (q.size() < 3) q.push_back(8'hxx);
        chk("tx word 0", 8'h15, q[0]);
        chk("tx word 1", 8'h1f, q[1]);
        chk("tx word 2", 8'h1c, q[2]);
        rd(ahsi_pkg::SEL_STATUS, 8'h70, "status tx drained");
        $display("done t_tx");
    endtask
    task automatic t_rx;
        irq_en = '{rx_en: 1'b1, tx_en: 1'b0, modem_en: 1'b0};
        word_len = ahsi_pkg::WL_7;
        rx_put(8'hd5, 1'b1, 1'b0);
        rd(ahsi_pkg::SEL_STATUS, 8'hfa, "status rx framing");
        rx_put(8'h2a, 1'b0, 1'b1);
        rd(ahsi_pkg::SEL_STATUS, 8'h7e, "status overrun");
        chk("irq line errors", 8'h01, {7'h00, intr_req_n});
        wr(ahsi_pkg::SEL_STATUS, 8'h00);
        rd(ahsi_pkg::SEL_STATUS, 8'h7a, "status program reset");
        rd(ahsi_pkg::SEL_DATA, 8'h55, "rx data masked");
        rd(ahsi_pkg::SEL_STATUS, 8'h70, "status errors cleared");
        rx_put(8'h80, 1'b0, 1'b1);
        rd(ahsi_pkg::SEL_STATUS, 8'hf9, "status rx parity");
        rd(ahsi_pkg::SEL_DATA, 8'h00, "rx parity stripped");
        word_len = ahsi_pkg::WL_6;
        rx_put(8'hd1, 1'b0, 1'b0);
        rd(ahsi_pkg::SEL_DATA, 8'h11, "rx data six bits");
        rx_put(8'h11, 1'b1, 1'b1);
        hw_reset_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        hw_reset_n = 1'b1;
        rd(ahsi_pkg::SEL_STATUS, 8'h70, "status after pin reset");
        $display("done t_rx");
    endtask
    task automatic t_modem;
        irq_en = '{rx_en: 1'b0, tx_en: 1'b0, modem_en: 1'b1};
        carrier_detect_n = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("irq line modem", 8'h00, {7'h00, intr_req_n});
        rd(ahsi_pkg::SEL_STATUS, 8'hd0, "status carrier low");
        carrier_detect_n = 1'b1;
        repeat (3) @(posedge clk);
        rd(ahsi_pkg::SEL_STATUS, 8'hf0, "status carrier high");
        irq_en = '0;
        rd(ahsi_pkg::SEL_STATUS, 8'h70, "status modem quiet");
        $display("done t_modem");
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        hw_reset_n = 1'b1;
        word_len = ahsi_pkg::WL_8;
        irq_en = '0;
        set_ready_n = 1'b1;
        carrier_detect_n = 1'b1;
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_word = '0;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset;
        t_tx;
        t_rx;
        t_modem;
        conclude;
    end
    // a hang counts as a mismatch
    initial begin
        #100000;
        mismatches++;
        conclude;
    end
endmodule

// [ahsi_pkg.sv]
// package: constants and carrier types for the host-side status interface
package ahsi_pkg;
    // ------------------------------------------------------------
    // register select codes (reg_sel_hi, reg_sel_lo)
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_DATA = 2'h0;
    localparam logic [1:0] SEL_STATUS = 2'h1;
    localparam logic [1:0] SEL_COMMAND = 2'h2;
    localparam logic [1:0] SEL_CONTROL = 2'h3;

    // ------------------------------------------------------------
    // status field positions
    // ------------------------------------------------------------
    localparam int ST_PARITY = 0;
    localparam int ST_FRAMING = 1;
    localparam int ST_OVERRUN = 2;
    localparam int ST_RX_FULL = 3;
    localparam int ST_TX_EMPTY = 4;
    localparam int ST_CARRIER = 5;
    localparam int ST_SET_READY = 6;
    localparam int ST_INTR = 7;

    // ------------------------------------------------------------
    // reset values and word length codes
    // ------------------------------------------------------------
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [1:0] MODEM_RST = 2'h3;
    localparam logic TX_EMPTY_RST = 1'b1;
    localparam logic [1:0] WL_8 = 2'h0;
    localparam logic [1:0] WL_7 = 2'h1;
    localparam logic [1:0] WL_6 = 2'h2;
    localparam logic [7:0] MASK_8 = 8'hff;
    localparam logic [7:0] MASK_7 = 8'h7f;
    localparam logic [7:0] MASK_6 = 8'h3f;
    localparam logic [7:0] MASK_5 = 8'h1f;
    localparam int BUF_DEPTH = 2;

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] data;
        logic framing_err;
        logic parity_err;
    } ahsi_rx_word_t;

    typedef struct packed {
        logic rx_en;
        logic tx_en;
        logic modem_en;
    } ahsi_irq_en_t;
endpackage
